/* File: smr_pkg.sv */
// Constants, register map and carrier types of the serial mode/status bank.
// Assumes one system clock domain and a plain strobe-based register port.
package smr_pkg;

    localparam int SMR_ADDR_W = 8;
    localparam int SMR_DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] SMR_ADDR_MODE_STATUS = 8'h00;
    localparam logic [7:0] SMR_ADDR_BAUD_IDLE = 8'h04;
    localparam logic [7:0] SMR_ADDR_XFER_CTRL = 8'h08;
    localparam logic [7:0] SMR_ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] SMR_ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] SMR_ADDR_IRQ_CLEAR = 8'h14;

    // Field positions.
    localparam int SMR_MODE_LSB = 2;
    localparam int SMR_MODE_MSB = 3;
    localparam int SMR_BIT_XFER = 3;
    localparam int SMR_BIT_SHIFT = 2;
    localparam int SMR_BIT_IDLE_RUN = 6;
    localparam int SMR_BIT_BAUD_ZERO = 0;
    localparam int SMR_BIT_START = 7;
    localparam int SMR_BIT_ABORT = 6;

    // Constant one-fill patterns of unused bits, and the all-zero read word.
    localparam logic [31:0] SMR_SIO_FILL = 32'h0000_00F3;
    localparam logic [31:0] SMR_BAUD_FILL = 32'h0000_00BE;
    localparam logic [31:0] SMR_ZERO_WORD = 32'h0000_0000;

    // Interrupt event bits.
    localparam int SMR_IRQ_W = 3;
    localparam int SMR_IRQ_DONE = 0;
    localparam int SMR_IRQ_ABORT = 1;
    localparam int SMR_IRQ_BYTE = 2;

    typedef enum logic [1:0] {
        SMR_MODE_PORT = 2'h0,
        SMR_MODE_SIO = 2'h1,
        SMR_MODE_TWI = 2'h2,
        SMR_MODE_RSVD = 2'h3
    } smr_mode_t;

    localparam smr_mode_t SMR_MODE_RST = SMR_MODE_PORT;
    localparam logic SMR_IDLE_RUN_RST = 1'b0;

    // Controls towards the shift engine.
    typedef struct packed {
        smr_mode_t mode;
        logic run;
        logic abort;
        logic halt;
    } smr_ctrl_t;

    // Status coming back from the shift engine.
    typedef struct packed {
        logic shift_busy;
        logic byte_done;
    } smr_eng_t;

endpackage

/* File: smr_reset_sync.sv */
// Reset release synchroniser for the serial mode/status bank.
// Assumes an active-low asynchronous reset from the system.
`timescale 1ns/1ps
module smr_reset_sync (
    // Clock and raw reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Released reset
    output logic o_reset_n
);
    logic meta_n;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_n <= 1'b0;
            o_reset_n <= 1'b0;
        end else begin
            meta_n <= 1'b1;
            o_reset_n <= meta_n;
        end
    end
endmodule

/* File: smr_irq_bank.sv */
// Sticky interrupt status bits with enable gating onto one level output.
// Assumes event and clear inputs are one-cycle pulses in the clock domain.
`timescale 1ns/1ps
module smr_irq_bank #(
    parameter int N = 3
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Events, clears and enables
    input wire logic [N-1:0] i_event,
    input wire logic [N-1:0] i_clear,
    input wire logic [N-1:0] i_enable,
    // Status and interrupt
    output logic [N-1:0] o_status,
    output logic o_irq
);
    if (N < 1) begin : g_bad_width
        $error("smr_irq_bank needs at least one event");
    end

    // A set in the same cycle as a clear wins, so no event is lost.
    for (genvar g = 0; g < N; g++) begin : g_bit
        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_status[g] <= 1'b0;
            end else if (i_event[g]) begin
                o_status[g] <= 1'b1;
            end else if (i_clear[g]) begin
                o_status[g] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((o_status & ~i_clear | i_event) & i_enable);
        end
    end

    a_irq_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ##1 (o_irq == |(o_status & $past(i_enable))))
        else $error("interrupt level does not follow enabled status");
endmodule

/* File: smr_regs.sv */
// Mode selection, transfer status and idle control of a serial interface.
// Assumes a shift engine beside it that reports busy and byte completion,
// and a power controller that raises a level while the system idles.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps

module smr_regs
    import smr_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Register port
    input wire logic [SMR_ADDR_W-1:0] i_addr,
    input wire logic [SMR_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [SMR_DATA_W-1:0] o_rdata,
    // Shift engine
    input wire smr_eng_t i_eng,
    output smr_ctrl_t o_ctrl,
    // Power controller
    input wire logic i_sys_idle,
    // Interrupt
    output logic o_irq
);
    typedef enum logic [1:0] {
        XS_IDLE,
        XS_RUN,
        XS_DRAIN
    } smr_xfer_state_t;

    logic rst_n;
    smr_mode_t mode;
    logic idle_run;
    logic baud_zero;
    logic start;
    logic abort;
    logic shift_flag;
    smr_xfer_state_t state;
    smr_xfer_state_t next_state;
    logic halted;
    logic wr_mode;
    logic wr_baud;
    logic wr_ctrl;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic start_req;
    logic abort_req;
    logic [SMR_IRQ_W-1:0] irq_enable;
    logic [SMR_IRQ_W-1:0] irq_clear;
    logic [SMR_IRQ_W-1:0] irq_event;
    logic [SMR_IRQ_W-1:0] irq_status;

    smr_reset_sync u_reset_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .o_reset_n(rst_n)
    );

    function automatic logic addr_is(input logic [SMR_ADDR_W-1:0] a,
                                     input logic [SMR_ADDR_W-1:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    assign wr_mode = i_wr && addr_is(i_addr, SMR_ADDR_MODE_STATUS);
    assign wr_baud = i_wr && addr_is(i_addr, SMR_ADDR_BAUD_IDLE);
    assign wr_ctrl = i_wr && addr_is(i_addr, SMR_ADDR_XFER_CTRL);
    assign wr_irq_en = i_wr && addr_is(i_addr, SMR_ADDR_IRQ_ENABLE);
    assign wr_irq_clr = i_wr && addr_is(i_addr, SMR_ADDR_IRQ_CLEAR);
    assign start_req = wr_ctrl && i_wdata[SMR_BIT_START];
    assign abort_req = wr_ctrl && i_wdata[SMR_BIT_ABORT];

    // Halt only while idling and software has not asked to keep running.
    assign halted = i_sys_idle && !idle_run;

    // Mode is taken on any write; software keeps it still mid-session.
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= SMR_MODE_RST;
        end else if (wr_mode) begin
            mode <= smr_mode_t'(i_wdata[SMR_MODE_MSB:SMR_MODE_LSB]);
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_run <= SMR_IDLE_RUN_RST;
            baud_zero <= 1'b0;
        end else if (wr_baud) begin
            idle_run <= i_wdata[SMR_BIT_IDLE_RUN];
            baud_zero <= i_wdata[SMR_BIT_BAUD_ZERO];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start <= 1'b0;
            abort <= 1'b0;
        end else if (wr_ctrl) begin
            start <= i_wdata[SMR_BIT_START];
            abort <= i_wdata[SMR_BIT_ABORT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= '0;
        end else if (wr_irq_en) begin
            irq_enable <= i_wdata[SMR_IRQ_W-1:0];
        end
    end

    assign irq_clear = wr_irq_clr ? i_wdata[SMR_IRQ_W-1:0] : '0;

    // A transfer starts only from a start write; a start bit left standing
    // after completion does not relaunch one.
    always_comb begin
        next_state = state;
        case (state)
            XS_IDLE: begin
                if (start_req && !abort_req && mode == SMR_MODE_SIO
                    && !halted) begin
                    next_state = XS_RUN;
                end
            end
            XS_RUN: begin
                if (abort_req) begin
                    next_state = XS_IDLE;
                end else if (wr_ctrl && !start_req) begin
                    next_state = XS_DRAIN;
                end
            end
            XS_DRAIN: begin
                if (abort_req) begin
                    next_state = XS_IDLE;
                end else if (i_eng.byte_done || !i_eng.shift_busy) begin
                    next_state = XS_IDLE;
                end
            end
            default: begin
                next_state = XS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= XS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Shift status is dropped with an abort, since the shifter is stopped.
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_flag <= 1'b0;
        end else begin
            shift_flag <= i_eng.shift_busy && !abort_req
                && next_state != XS_IDLE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ctrl <= '{mode: SMR_MODE_RST, run: 1'b0, abort: 1'b0,
                        halt: 1'b0};
        end else begin
            o_ctrl.mode <= wr_mode
                ? smr_mode_t'(i_wdata[SMR_MODE_MSB:SMR_MODE_LSB]) : mode;
            o_ctrl.run <= (next_state == XS_RUN);
            o_ctrl.abort <= abort_req || (abort && !wr_ctrl);
            o_ctrl.halt <= halted;
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[SMR_IRQ_DONE] = state != XS_IDLE && next_state == XS_IDLE
            && !abort_req;
        irq_event[SMR_IRQ_ABORT] = state != XS_IDLE && abort_req;
        irq_event[SMR_IRQ_BYTE] = i_eng.byte_done && state != XS_IDLE;
    end

    smr_irq_bank #(
        .N(SMR_IRQ_W)
    ) u_irq_bank (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_event(irq_event),
        .i_clear(irq_clear),
        .i_enable(irq_enable),
        .o_status(irq_status),
        .o_irq(o_irq)
    );

    function automatic logic [31:0] read_word(
        input logic [SMR_ADDR_W-1:0] a);
        logic [31:0] w;
        w = SMR_ZERO_WORD;
        if (addr_is(a, SMR_ADDR_MODE_STATUS)) begin
            // The mode field is write-only; the address reads as status.
            if (mode == SMR_MODE_SIO) begin
                w = SMR_SIO_FILL;
            end
            w[SMR_BIT_XFER] = (state != XS_IDLE);
            w[SMR_BIT_SHIFT] = shift_flag;
        end else if (addr_is(a, SMR_ADDR_BAUD_IDLE)) begin
            w = SMR_BAUD_FILL;
            w[SMR_BIT_IDLE_RUN] = idle_run;
            w[SMR_BIT_BAUD_ZERO] = baud_zero;
        end else if (addr_is(a, SMR_ADDR_XFER_CTRL)) begin
            w[SMR_BIT_START] = start;
            w[SMR_BIT_ABORT] = abort;
        end else if (addr_is(a, SMR_ADDR_IRQ_STATUS)) begin
            w[SMR_IRQ_W-1:0] = irq_status;
        end else if (addr_is(a, SMR_ADDR_IRQ_ENABLE)) begin
            w[SMR_IRQ_W-1:0] = irq_enable;
        end
        read_word = w;
    endfunction

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= SMR_ZERO_WORD;
        end else if (i_rd) begin
            o_rdata <= read_word(i_addr);
        end else begin
            o_rdata <= SMR_ZERO_WORD;
        end
    end

    a_mode_written: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        wr_mode |=> mode == $past(i_wdata[SMR_MODE_MSB:SMR_MODE_LSB]))
        else $error("mode field not taken from write");

    a_xfer_start: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (state == XS_IDLE && start_req && !abort_req
            && mode == SMR_MODE_SIO && !halted)
        |=> state == XS_RUN && o_ctrl.run)
        else $error("start write did not begin a transfer");

    a_abort_stops: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        abort_req |=> state == XS_IDLE && !shift_flag)
        else $error("abort did not clear transfer status");

    a_drain_holds: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (state == XS_DRAIN && !abort_req && !i_eng.byte_done
            && i_eng.shift_busy) |=> state == XS_DRAIN)
        else $error("transfer ended before the byte finished");

    a_drain_ends: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (state == XS_DRAIN && i_eng.byte_done) |=> state == XS_IDLE)
        else $error("transfer status not cleared after the last byte");

    a_sio_fill: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (i_rd && addr_is(i_addr, SMR_ADDR_MODE_STATUS)
            && mode == SMR_MODE_SIO)
        |=> o_rdata[7:4] == 4'hF && o_rdata[1:0] == 2'h3
            && o_rdata[31:8] == 24'h0)
        else $error("unused status bits wrong in serial mode");

    a_status_read: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (i_rd && addr_is(i_addr, SMR_ADDR_MODE_STATUS))
        |=> o_rdata[SMR_BIT_XFER] == ($past(state) != XS_IDLE))
        else $error("status read does not show transfer state");

    a_idle_halt: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (i_sys_idle && !idle_run) |=> o_ctrl.halt)
        else $error("idle did not halt the serial engine");

    a_halt_released: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (!i_sys_idle || idle_run) |=> !o_ctrl.halt)
        else $error("engine halted outside idle");

    a_idle_bit: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        wr_baud |=> idle_run == $past(i_wdata[SMR_BIT_IDLE_RUN]))
        else $error("idle-run bit not stored");

    a_baud_fill: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (i_rd && addr_is(i_addr, SMR_ADDR_BAUD_IDLE))
        |=> (o_rdata & SMR_BAUD_FILL) == SMR_BAUD_FILL)
        else $error("unused baud bits do not read one");

    a_read_once: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        !i_rd |=> o_rdata == SMR_ZERO_WORD)
        else $error("read data held beyond one cycle");

    // The engine sees run exactly while the transfer is in XS_RUN, not while it drains.
    a_run_output: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        o_ctrl.run == (state == XS_RUN))
        else $error("run control does not match transfer state");

    a_port_no_start: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (state == XS_IDLE && mode != SMR_MODE_SIO) |=> state == XS_IDLE)
        else $error("transfer started outside serial mode");

    a_abort_output: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        abort_req |=> o_ctrl.abort && !o_ctrl.run)
        else $error("abort not passed to the shift engine");

    a_shift_idle: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        state == XS_IDLE |-> !shift_flag)
        else $error("shift status set with no transfer");

    a_shift_follows: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (state == XS_RUN && i_eng.shift_busy && !wr_ctrl) |=> shift_flag)
        else $error("shift status missed a busy shifter");

    a_done_event: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (state == XS_DRAIN && i_eng.byte_done && !abort_req)
        |=> irq_status[SMR_IRQ_DONE])
        else $error("transfer completion not recorded");

    a_abort_event: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n)
        (state != XS_IDLE && abort_req) |=> irq_status[SMR_IRQ_ABORT])
        else $error("transfer abort not recorded");
endmodule

/* File: smr_tb.sv */
// Self-checking bench for the serial mode/status register bank.
// Assumes smr_pkg and smr_regs are compiled first; the bench drives all ports.
`timescale 1ns/1ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module tb
    import smr_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [SMR_ADDR_W-1:0] i_addr = '0;
    logic [SMR_DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [SMR_DATA_W-1:0] o_rdata;
    smr_eng_t i_eng = '0;
    smr_ctrl_t o_ctrl;
    logic i_sys_idle = 1'b0;
    logic o_irq;
    int failures = 0;
    int samples_checked = 0;
    integer seed = 32'he6ba;
    logic [31:0] rv;
    logic [31:0] w;
    logic idle;
    int k;
    // Model of the stored settings, kept from the rules alone.
    int mdl_mode = 0;
    int mdl_idle_run = 0;

    always #25 i_sys_clk = ~i_sys_clk;

    smr_regs dut_u (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_eng(i_eng),
        .o_ctrl(o_ctrl),
        .i_sys_idle(i_sys_idle),
        .o_irq(o_irq)
    );

    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write and read lower their strobe at the taking edge, so the next
    // call always waits for a fresh edge before raising it again.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        if (a == SMR_ADDR_MODE_STATUS) begin
            mdl_mode = int'(d[SMR_MODE_MSB:SMR_MODE_LSB]);
        end
        if (a == SMR_ADDR_BAUD_IDLE) begin
            mdl_idle_run = int'(d[SMR_BIT_IDLE_RUN]);
        end
        #1;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    function automatic logic [31:0] mdl_baud();
        return SMR_BAUD_FILL | (32'(mdl_idle_run) << SMR_BIT_IDLE_RUN);
    endfunction

    task automatic eng_set(input logic busy, input logic done);
        @(posedge i_sys_clk);
        i_eng <= '{shift_busy: busy, byte_done: done};
    endtask

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (o_irq !== lvl && n < 8) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        if (o_irq !== lvl) begin
            failures++;
            $display("MISMATCH t=%0t irq=%h exp=%h", $time, o_irq, lvl);
            final_report();
        end
    endtask

    initial begin
        #(50 * 20000);
        failures++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        reg_rd(SMR_ADDR_MODE_STATUS, rv);
        `CHK(rv, SMR_ZERO_WORD);
        `CHK(o_ctrl, 5'h00);
        reg_rd(SMR_ADDR_BAUD_IDLE, rv);
        `CHK(rv, SMR_BAUD_FILL);
        reg_rd(8'h3C, rv);
        `CHK(rv, SMR_ZERO_WORD);
        // Every mode code; unused bits read one only in serial mode.
        for (k = 0; k < 4; k++) begin
            reg_wr(SMR_ADDR_MODE_STATUS, 32'(k) << SMR_MODE_LSB);
            reg_rd(SMR_ADDR_MODE_STATUS, rv);
            `CHK(o_ctrl.mode, mdl_mode);
            `CHK(rv, (k == 1) ? SMR_SIO_FILL : SMR_ZERO_WORD);
        end
        // Random idle-run settings against a random idle indication.
        for (k = 0; k < 6; k++) begin
            w = $random(seed) & 32'hFFFF_FFFE;
            idle = w[9];
            @(posedge i_sys_clk);
            i_sys_idle <= idle;
            reg_wr(SMR_ADDR_BAUD_IDLE, w);
            reg_rd(SMR_ADDR_BAUD_IDLE, rv);
            `CHK(rv, mdl_baud());
            `CHK(o_ctrl.halt, idle & (mdl_idle_run == 0));
        end
        @(posedge i_sys_clk);
        i_sys_idle <= 1'b0;
        reg_wr(SMR_ADDR_BAUD_IDLE, 32'h0000_0040);
        reg_wr(SMR_ADDR_MODE_STATUS, 32'h0000_0004);
        reg_wr(SMR_ADDR_IRQ_ENABLE, 32'h0000_0007);
        // Start, shift, stop with drain, then done event.
        eng_set(1'b1, 1'b0);
        reg_wr(SMR_ADDR_XFER_CTRL, 32'h0000_0080);
        `CHK(o_ctrl.run, 1'b1);
        reg_rd(SMR_ADDR_MODE_STATUS, rv);
        `CHK(rv, 32'h0000_00FF);
        `CHK(o_irq, 1'b0);
        reg_wr(SMR_ADDR_XFER_CTRL, 32'h0000_0000);
        reg_rd(SMR_ADDR_MODE_STATUS, rv);
        `CHK(rv, 32'h0000_00FF);
        eng_set(1'b0, 1'b1);
        eng_set(1'b0, 1'b0);
        wait_irq(1'b1);
        reg_rd(SMR_ADDR_MODE_STATUS, rv);
        `CHK(rv, SMR_SIO_FILL);
        reg_rd(SMR_ADDR_IRQ_STATUS, rv);
        `CHK(rv, 32'h0000_0005);
        reg_wr(SMR_ADDR_IRQ_CLEAR, 32'h0000_0007);
        wait_irq(1'b0);
        reg_rd(SMR_ADDR_IRQ_STATUS, rv);
        `CHK(rv, SMR_ZERO_WORD);
        // Forced abort while shifting ends the transfer at once.
        eng_set(1'b1, 1'b0);
        reg_wr(SMR_ADDR_XFER_CTRL, 32'h0000_0080);
        reg_wr(SMR_ADDR_XFER_CTRL, 32'h0000_0040);
        `CHK(o_ctrl.abort, 1'b1);
        `CHK(o_ctrl.run, 1'b0);
        reg_rd(SMR_ADDR_MODE_STATUS, rv);
        `CHK(rv, SMR_SIO_FILL);
        reg_rd(SMR_ADDR_IRQ_STATUS, rv);
        `CHK(rv, 32'h0000_0002);
        // A masked event stays sticky but keeps the interrupt low.
        reg_wr(SMR_ADDR_IRQ_ENABLE, 32'h0000_0001);
        wait_irq(1'b0);
        reg_wr(SMR_ADDR_IRQ_ENABLE, 32'h0000_0002);
        wait_irq(1'b1);
        reg_wr(SMR_ADDR_IRQ_CLEAR, 32'h0000_0002);
        wait_irq(1'b0);
        eng_set(1'b0, 1'b0);
        reg_wr(SMR_ADDR_XFER_CTRL, 32'h0000_0000);
        reg_rd(SMR_ADDR_XFER_CTRL, rv);
        `CHK(rv, SMR_ZERO_WORD);
        `CHK(o_ctrl.abort, 1'b0);
        // A reset after the transfer has ended drops every setting back to its reset value.
        @(posedge i_sys_clk);
        i_reset_n <= 1'b0;
        mdl_mode = 0;
        mdl_idle_run = 0;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        `CHK(o_ctrl, 5'h00);
        reg_rd(SMR_ADDR_BAUD_IDLE, rv);
        `CHK(rv, mdl_baud());
        reg_rd(SMR_ADDR_MODE_STATUS, rv);
        `CHK(rv, SMR_ZERO_WORD);
        final_report();
    end
endmodule
